// ===== core/lifl_irq.v
`timescale 1ns/100ps
`default_nettype none
`include "lifl_defs.vh"

module lifl_irq #(
  parameter HAS_TONE_DECODER = 1
) (
  input  wire                    clock,
  input  wire                    rst,
  input  wire [`LIFL_AW-1:0]     reg_addr,
  input  wire                    reg_wr,
  input  wire                    reg_rd,
  input  wire [`LIFL_DW-1:0]     reg_wdata,
  output reg  [`LIFL_DW-1:0]     reg_rdata,
  output reg                     reg_rvalid,
  output reg                     reg_rhit,
  input  wire                    meter_inactive_evt,
  input  wire                    meter_active_evt,
  input  wire                    ring_inactive_evt,
  input  wire                    ring_active_evt,
  input  wire                    osc2_inactive_evt,
  input  wire                    osc2_active_evt,
  input  wire                    osc1_inactive_evt,
  input  wire                    osc1_active_evt,
  input  wire [5:0]              power_alarm_evt,
  input  wire                    loop_closure_evt,
  input  wire                    ring_trip_evt,
  input  wire                    hook_state,
  input  wire                    cal_running,
  input  wire                    indirect_done_evt,
  input  wire                    tone_digit_evt,
  output reg                     irq
);

  // address match, used by the write decode; the read mux uses its own case
  function addr_is;
    input [`LIFL_AW-1:0] addr;
    input [`LIFL_AW-1:0] target;
    begin
      addr_is = (addr == target);
    end
  endfunction

  // mask update: keeps only implemented bits
  function [`LIFL_DW-1:0] mask_next;
    input                cur_wr;
    input [`LIFL_DW-1:0] cur;
    input [`LIFL_DW-1:0] wdata;
    input [`LIFL_DW-1:0] valid;
    begin
      mask_next = (cur_wr ? wdata : cur) & valid;
    end
  endfunction

  wire [`LIFL_DW-1:0] grp3_valid;
  wire [`LIFL_DW-1:0] pend1;
  wire [`LIFL_DW-1:0] pend2;
  wire [`LIFL_DW-1:0] pend3;
  wire [`LIFL_DW-1:0] set1;
  wire [`LIFL_DW-1:0] set2;
  wire [`LIFL_DW-1:0] set3;
  wire                wr_pend1;
  wire                wr_pend2;
  wire                wr_pend3;
  wire                wr_mask1;
  wire                wr_mask2;
  wire                wr_mask3;
  wire                cal_error_evt;
  wire                irq_d;

  reg  [`LIFL_DW-1:0] mask1_q;
  reg  [`LIFL_DW-1:0] mask2_q;
  reg  [`LIFL_DW-1:0] mask3_q;
  reg                 hook_prev_q;
  reg                 hook_seen_q;
  reg  [`LIFL_DW-1:0] rdata_d;
  reg                 rhit_d;

  // tone bit exists only with the decoder; otherwise reads 0
  assign grp3_valid = (HAS_TONE_DECODER != 0) ? `LIFL_VALID_GRP3 : `LIFL_VALID_GRP3_NT;

  assign wr_pend1 = reg_wr & addr_is(reg_addr, `LIFL_ADDR_PEND1);
  assign wr_pend2 = reg_wr & addr_is(reg_addr, `LIFL_ADDR_PEND2);
  assign wr_pend3 = reg_wr & addr_is(reg_addr, `LIFL_ADDR_PEND3);
  assign wr_mask1 = reg_wr & addr_is(reg_addr, `LIFL_ADDR_MASK1);
  assign wr_mask2 = reg_wr & addr_is(reg_addr, `LIFL_ADDR_MASK2);
  assign wr_mask3 = reg_wr & addr_is(reg_addr, `LIFL_ADDR_MASK3);

  // hook edge while calibration runs; first sample after reset is no edge
  assign cal_error_evt = cal_running & hook_seen_q & (hook_state != hook_prev_q);

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      hook_prev_q <= 1'b0;
      hook_seen_q <= 1'b0;
    end else begin
      hook_prev_q <= hook_state;
      hook_seen_q <= 1'b1;
    end
  end

  // timer events, paired bit for bit with mask 1
  assign set1[`LIFL_BIT_MTR_INACT] = meter_inactive_evt;
  assign set1[`LIFL_BIT_MTR_ACT]   = meter_active_evt;
  assign set1[`LIFL_BIT_RNG_INACT] = ring_inactive_evt;
  assign set1[`LIFL_BIT_RNG_ACT]   = ring_active_evt;
  assign set1[`LIFL_BIT_O2_INACT]  = osc2_inactive_evt;
  assign set1[`LIFL_BIT_O2_ACT]    = osc2_active_evt;
  assign set1[`LIFL_BIT_O1_INACT]  = osc1_inactive_evt;
  assign set1[`LIFL_BIT_O1_ACT]    = osc1_active_evt;

  // alarm sixth down to first in bits 7..2
  assign set2[`LIFL_BIT_PA_HI:`LIFL_BIT_PA_LO] = power_alarm_evt;
  assign set2[`LIFL_BIT_LOOP]  = loop_closure_evt;
  assign set2[`LIFL_BIT_RTRIP] = ring_trip_evt;

  assign set3[`LIFL_DW-1:`LIFL_BIT_CAL+1] = 5'h00;
  assign set3[`LIFL_BIT_CAL]  = cal_error_evt;
  assign set3[`LIFL_BIT_IND]  = indirect_done_evt;
  assign set3[`LIFL_BIT_TONE] = tone_digit_evt;

  // write-one-to-clear flag banks
  lifl_flag_bank u_pend1 (
    .clock      (clock),
    .rst        (rst),
    .valid_bits (`LIFL_VALID_FULL),
    .set_evt    (set1),
    .clr_wr     (wr_pend1),
    .clr_data   (reg_wdata),
    .flags_q    (pend1)
  );

  lifl_flag_bank u_pend2 (
    .clock      (clock),
    .rst        (rst),
    .valid_bits (`LIFL_VALID_FULL),
    .set_evt    (set2),
    .clr_wr     (wr_pend2),
    .clr_data   (reg_wdata),
    .flags_q    (pend2)
  );

  lifl_flag_bank u_pend3 (
    .clock      (clock),
    .rst        (rst),
    .valid_bits (grp3_valid),
    .set_evt    (set3),
    .clr_wr     (wr_pend3),
    .clr_data   (reg_wdata),
    .flags_q    (pend3)
  );

  // enable masks, plain read/write storage
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      mask1_q <= `LIFL_RST_MASK;
      mask2_q <= `LIFL_RST_MASK;
      mask3_q <= `LIFL_RST_MASK;
    end else begin
      mask1_q <= mask_next(wr_mask1, mask1_q, reg_wdata, `LIFL_VALID_FULL);
      mask2_q <= mask_next(wr_mask2, mask2_q, reg_wdata, `LIFL_VALID_FULL);
      mask3_q <= mask_next(wr_mask3, mask3_q, reg_wdata, grp3_valid);
    end
  end

  // named views of the mask fields
  wire       meter_inactive_enable;
  wire       meter_active_enable;
  wire       ring_inactive_enable;
  wire       ring_active_enable;
  wire       osc2_inactive_enable;
  wire       osc2_active_enable;
  wire       osc1_inactive_enable;
  wire       osc1_active_enable;
  wire [5:0] power_alarm_enable;
  wire       loop_closure_enable;
  wire       ring_trip_enable;
  wire       cal_error_enable;
  wire       indirect_done_enable;
  wire       tone_digit_enable;

  assign meter_inactive_enable = mask1_q[`LIFL_BIT_MTR_INACT];
  assign meter_active_enable   = mask1_q[`LIFL_BIT_MTR_ACT];
  assign ring_inactive_enable  = mask1_q[`LIFL_BIT_RNG_INACT];
  assign ring_active_enable    = mask1_q[`LIFL_BIT_RNG_ACT];
  assign osc2_inactive_enable  = mask1_q[`LIFL_BIT_O2_INACT];
  assign osc2_active_enable    = mask1_q[`LIFL_BIT_O2_ACT];
  assign osc1_inactive_enable  = mask1_q[`LIFL_BIT_O1_INACT];
  assign osc1_active_enable    = mask1_q[`LIFL_BIT_O1_ACT];
  assign power_alarm_enable    = mask2_q[`LIFL_BIT_PA_HI:`LIFL_BIT_PA_LO];
  assign loop_closure_enable   = mask2_q[`LIFL_BIT_LOOP];
  assign ring_trip_enable      = mask2_q[`LIFL_BIT_RTRIP];
  assign cal_error_enable      = mask3_q[`LIFL_BIT_CAL];
  assign indirect_done_enable  = mask3_q[`LIFL_BIT_IND];
  assign tone_digit_enable     = mask3_q[`LIFL_BIT_TONE];

  // named views of the pending fields
  wire       meter_inactive_pending;
  wire       meter_active_pending;
  wire       ring_inactive_pending;
  wire       ring_active_pending;
  wire       osc2_inactive_pending;
  wire       osc2_active_pending;
  wire       osc1_inactive_pending;
  wire       osc1_active_pending;
  wire [5:0] power_alarm_pending;
  wire       loop_closure_pending;
  wire       ring_trip_pending;
  wire       cal_error_pending;
  wire       indirect_done_pending;
  wire       tone_digit_pending;

  assign meter_inactive_pending = pend1[`LIFL_BIT_MTR_INACT];
  assign meter_active_pending   = pend1[`LIFL_BIT_MTR_ACT];
  assign ring_inactive_pending  = pend1[`LIFL_BIT_RNG_INACT];
  assign ring_active_pending    = pend1[`LIFL_BIT_RNG_ACT];
  assign osc2_inactive_pending  = pend1[`LIFL_BIT_O2_INACT];
  assign osc2_active_pending    = pend1[`LIFL_BIT_O2_ACT];
  assign osc1_inactive_pending  = pend1[`LIFL_BIT_O1_INACT];
  assign osc1_active_pending    = pend1[`LIFL_BIT_O1_ACT];
  assign power_alarm_pending    = pend2[`LIFL_BIT_PA_HI:`LIFL_BIT_PA_LO];
  assign loop_closure_pending   = pend2[`LIFL_BIT_LOOP];
  assign ring_trip_pending      = pend2[`LIFL_BIT_RTRIP];
  assign cal_error_pending      = pend3[`LIFL_BIT_CAL];
  assign indirect_done_pending  = pend3[`LIFL_BIT_IND];
  assign tone_digit_pending     = pend3[`LIFL_BIT_TONE];

  // per-source gating, mask 0 blocks, 1 passes
  wire timer_req =
    (meter_inactive_pending & meter_inactive_enable) |
    (meter_active_pending   & meter_active_enable)   |
    (ring_inactive_pending  & ring_inactive_enable)  |
    (ring_active_pending    & ring_active_enable)    |
    (osc2_inactive_pending  & osc2_inactive_enable)  |
    (osc2_active_pending    & osc2_active_enable)    |
    (osc1_inactive_pending  & osc1_inactive_enable)  |
    (osc1_active_pending    & osc1_active_enable);

  wire line_req =
    (|(power_alarm_pending & power_alarm_enable)) |
    (loop_closure_pending & loop_closure_enable)  |
    (ring_trip_pending    & ring_trip_enable);

  wire misc_req =
    (cal_error_pending     & cal_error_enable)     |
    (indirect_done_pending & indirect_done_enable) |
    (tone_digit_pending    & tone_digit_enable);

  assign irq_d = timer_req | line_req | misc_req;

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= irq_d;
    end
  end

  // read mux; reserved bits already zero in storage
  always @* begin
    rdata_d = `LIFL_ZERO;
    rhit_d  = 1'b1;
    case (reg_addr)
      `LIFL_ADDR_PEND1: begin
        rdata_d = pend1;
      end
      `LIFL_ADDR_PEND2: begin
        rdata_d = pend2;
      end
      `LIFL_ADDR_PEND3: begin
        rdata_d = pend3;
      end
      `LIFL_ADDR_MASK1: begin
        rdata_d = mask1_q;
      end
      `LIFL_ADDR_MASK2: begin
        rdata_d = mask2_q;
      end
      `LIFL_ADDR_MASK3: begin
        rdata_d = mask3_q;
      end
      default: begin
        rdata_d = `LIFL_ZERO;
        rhit_d  = 1'b0;
      end
    endcase
  end

  // read answer one cycle after the strobe, held until the next read
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      reg_rdata  <= `LIFL_ZERO;
      reg_rvalid <= 1'b0;
      reg_rhit   <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        reg_rdata <= rdata_d;
        reg_rhit  <= rhit_d;
      end
    end
  end

endmodule
`default_nettype wire

// ===== core/lifl_defs.vh
`ifndef LIFL_DEFS_VH
`define LIFL_DEFS_VH

`define LIFL_AW            8
`define LIFL_DW            8

`define LIFL_ADDR_PEND1    8'h12
`define LIFL_ADDR_PEND2    8'h13
`define LIFL_ADDR_PEND3    8'h14
`define LIFL_ADDR_MASK1    8'h15
`define LIFL_ADDR_MASK2    8'h16
`define LIFL_ADDR_MASK3    8'h17

`define LIFL_RST_PEND      8'h00
`define LIFL_RST_MASK      8'h00
`define LIFL_ZERO          8'h00

`define LIFL_VALID_FULL    8'hFF
`define LIFL_VALID_GRP3    8'h07
`define LIFL_VALID_GRP3_NT 8'h06

`define LIFL_BIT_PA_HI     7
`define LIFL_BIT_PA_LO     2
`define LIFL_BIT_LOOP      1
`define LIFL_BIT_RTRIP     0
`define LIFL_BIT_CAL       2
`define LIFL_BIT_IND       1
`define LIFL_BIT_TONE      0

`define LIFL_BIT_MTR_INACT 7
`define LIFL_BIT_MTR_ACT   6
`define LIFL_BIT_RNG_INACT 5
`define LIFL_BIT_RNG_ACT   4
`define LIFL_BIT_O2_INACT  3
`define LIFL_BIT_O2_ACT    2
`define LIFL_BIT_O1_INACT  1
`define LIFL_BIT_O1_ACT    0

`endif

// ===== core/lifl_flag_bank.v
`timescale 1ns/100ps
`default_nettype none
`include "lifl_defs.vh"

module lifl_flag_bank (
  input  wire                    clock,
  input  wire                    rst,
  input  wire [`LIFL_DW-1:0]     valid_bits,
  input  wire [`LIFL_DW-1:0]     set_evt,
  input  wire                    clr_wr,
  input  wire [`LIFL_DW-1:0]     clr_data,
  output reg  [`LIFL_DW-1:0]     flags_q
);

  wire [`LIFL_DW-1:0] clr_bits;
  wire [`LIFL_DW-1:0] flags_d;

  // only ones in the write data clear
  assign clr_bits = clr_wr ? clr_data : `LIFL_ZERO;

  // clear first, then set, so a same-cycle event survives
  assign flags_d = ((flags_q & ~clr_bits) | set_evt) & valid_bits;

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      flags_q <= `LIFL_RST_PEND;
    end else begin
      flags_q <= flags_d;
    end
  end

endmodule
`default_nettype wire

// ===== tb/lifl_irq_checker.sv
`timescale 1ns/100ps
`default_nettype none
module lifl_irq_checker #(
  parameter HAS_TONE_DECODER = 1
) (
  input wire logic       clock,
  input wire logic       rst,
  input wire logic [7:0] reg_addr,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic       reg_rvalid,
  input wire logic       reg_rhit,
  input wire logic [5:0] power_alarm_evt,
  input wire logic       loop_closure_evt,
  input wire logic       ring_trip_evt,
  input wire logic       hook_state,
  input wire logic       cal_running,
  input wire logic       tone_digit_evt
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  chk_read_valid: assert property (reg_rd |=> reg_rvalid)
    else $error("no valid after read");
  chk_alarm_flags: assert property (
    (power_alarm_evt != 6'h00) ##1 (reg_rd && reg_addr == 8'h13) |=>
    ((reg_rdata[7:2] & $past(power_alarm_evt, 2)) == $past(power_alarm_evt, 2)))
    else $error("alarm flag missing");
  chk_loop_flag: assert property (
    loop_closure_evt ##1 (reg_rd && reg_addr == 8'h13) |=> reg_rdata[1])
    else $error("loop flag missing");
  chk_trip_flag: assert property (
    ring_trip_evt ##1 (reg_rd && reg_addr == 8'h13) |=> reg_rdata[0])
    else $error("trip flag missing");
  chk_cal_flag: assert property (
    (cal_running && hook_state != $past(hook_state)) ##1 (reg_rd && reg_addr == 8'h14)
    |=> reg_rdata[2]) else $error("cal flag missing");
  chk_tone_flag: assert property (
    tone_digit_evt ##1 (reg_rd && reg_addr == 8'h14) |=>
    reg_rdata[0] == (HAS_TONE_DECODER != 0)) else $error("tone flag wrong");
  chk_mask_back: assert property (
    (reg_wr && reg_addr == 8'h16) ##2 (reg_rd && reg_addr == 8'h16) |=>
    reg_rdata == $past(reg_wdata, 3)) else $error("mask readback wrong");
  chk_mask3_rsvd: assert property (
    reg_rd && reg_addr == 8'h17 |=> reg_rdata[7:3] == 5'h00)
    else $error("mask3 reserved bits set");
  chk_unmapped_zero: assert property (
    reg_rd && (reg_addr < 8'h12 || reg_addr > 8'h17) |=> !reg_rhit && reg_rdata == 8'h00)
    else $error("unmapped read not zero");
endmodule
bind lifl_irq lifl_irq_checker #(.HAS_TONE_DECODER(HAS_TONE_DECODER)) u_chk (
  .clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
  .reg_rhit(reg_rhit), .power_alarm_evt(power_alarm_evt),
  .loop_closure_evt(loop_closure_evt), .ring_trip_evt(ring_trip_evt),
  .hook_state(hook_state), .cal_running(cal_running), .tone_digit_evt(tone_digit_evt));
`default_nettype wire

// ===== tb/lifl_host.sv
`timescale 1ns/100ps
`default_nettype none
module lifl_host (
  input  wire logic       clock,
  output var  logic [7:0] reg_addr,
  output var  logic       reg_wr,
  output var  logic       reg_rd,
  output var  logic [7:0] reg_wdata,
  input  wire logic [7:0] reg_rdata,
  input  wire logic       reg_rvalid
);
  logic rvalid_seen = 1'b0;
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
  end
  // one-cycle strobe then an idle cycle; a 1 clears a flag
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge clock);
    #1;
    reg_wr = 1'b0;
    @(posedge clock);
    #1;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge clock);
    #1;
    reg_rd = 1'b0;
    q = reg_rdata;
    rvalid_seen = reg_rvalid;
    @(posedge clock);
    #1;
  endtask
endmodule
`default_nettype wire

// ===== tb/line_interface_interrupt_flags_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module line_interface_interrupt_flags_tb_top;
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  reg_addr;
  logic        reg_wr;
  logic        reg_rd;
  logic [7:0]  reg_wdata;
  wire  [7:0]  reg_rdata;
  wire         rvalid;
  wire         rhit;
  wire         irq;
  wire  [7:0]  rdata_nt;
  wire         rvalid_nt;
  wire         rhit_nt;
  wire         irq_nt;
  logic        hook = 1'b0;
  logic        cal = 1'b0;
  logic [17:0] ev = 18'h00000;
  logic [7:0]  q;
  logic [7:0]  a;
  logic [7:0]  b;
  int          j;
  int          num_errors = 0;
  int          checked = 0;
  int          cycles = 0;
  always #4 clock = ~clock;
  lifl_host u_host (.clock(clock), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(rvalid));
  lifl_irq u_dut (.clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(rvalid),
    .reg_rhit(rhit), .meter_inactive_evt(ev[7]), .meter_active_evt(ev[6]),
    .ring_inactive_evt(ev[5]), .ring_active_evt(ev[4]), .osc2_inactive_evt(ev[3]),
    .osc2_active_evt(ev[2]), .osc1_inactive_evt(ev[1]), .osc1_active_evt(ev[0]),
    .power_alarm_evt(ev[15:10]), .loop_closure_evt(ev[9]), .ring_trip_evt(ev[8]),
    .hook_state(hook), .cal_running(cal), .indirect_done_evt(ev[17]),
    .tone_digit_evt(ev[16]), .irq(irq));
  lifl_irq #(.HAS_TONE_DECODER(0)) u_dut_nt (.clock(clock), .rst(rst), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(rdata_nt),
    .reg_rvalid(rvalid_nt), .reg_rhit(rhit_nt), .meter_inactive_evt(ev[7]),
    .meter_active_evt(ev[6]), .ring_inactive_evt(ev[5]), .ring_active_evt(ev[4]),
    .osc2_inactive_evt(ev[3]), .osc2_active_evt(ev[2]), .osc1_inactive_evt(ev[1]),
    .osc1_active_evt(ev[0]), .power_alarm_evt(ev[15:10]), .loop_closure_evt(ev[9]),
    .ring_trip_evt(ev[8]), .hook_state(hook), .cal_running(cal),
    .indirect_done_evt(ev[17]), .tone_digit_evt(ev[16]), .irq(irq_nt));
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic conclude;
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      num_errors++;
      conclude();
    end
  end
  initial begin
    repeat (2) @(posedge clock);
    #1;
    rst = 1'b0;
    for (j = 0; j < 6; j++) begin
      u_host.rd(8'h12 + 8'(j), q);
      chk("reset value", q, 8'h00);
    end
    u_host.rd(8'h18, q);
    chk("unmapped data", q, 8'h00);
    chk("unmapped hit", {7'h00, rhit}, 8'h00);
    ev[8] = 1'b1;
    @(posedge clock);
    #1;
    ev[8] = 1'b0;
    u_host.rd(8'h13, q);
    chk("masked flag", q, 8'h01);
    chk("masked irq", {7'h00, irq}, 8'h00);
    u_host.wr(8'h16, 8'h01);
    u_host.rd(8'h16, q);
    chk("trip enable", q, 8'h01);
    chk("read valid", {7'h00, u_host.rvalid_seen}, 8'h01);
    chk("valid one cycle", {7'h00, rvalid}, 8'h00);
    chk("mapped hit", {7'h00, rhit}, 8'h01);
    chk("enabled irq", {7'h00, irq}, 8'h01);
    ev[8] = 1'b1;
    fork
      u_host.wr(8'h13, 8'h01);
      begin
        @(posedge clock);
        #1;
        ev[8] = 1'b0;
      end
    join
    u_host.rd(8'h13, q);
    chk("set beats clear", q, 8'h01);
    u_host.wr(8'h13, 8'h01);
    for (j = 0; j < 3; j++) begin
      u_host.wr(8'h15 + 8'(j), 8'hFF);
      u_host.rd(8'h15 + 8'(j), q);
      chk("mask rw", q, (j == 2) ? 8'h07 : 8'hFF);
    end
    chk("mask3 rw", q, 8'h07);
    chk("mask3 variant", rdata_nt, 8'h06);
    for (j = 0; j < 18; j++) begin
      a = 8'h12 + 8'(j / 8);
      b = 8'(1 << (j % 8));
      ev[j] = 1'b1;
      @(posedge clock);
      #1;
      ev[j] = 1'b0;
      u_host.rd(a, q);
      chk("flag set", q, b);
      chk("variant flag", rdata_nt, (j == 16) ? 8'h00 : b);
      chk("irq on", {7'h00, irq}, 8'h01);
      chk("variant irq", {7'h00, irq_nt}, (j == 16) ? 8'h00 : 8'h01);
      u_host.wr(a, ~b);
      u_host.rd(a, q);
      chk("zero write", q, b);
      u_host.wr(a, b);
      u_host.rd(a, q);
      chk("flag clear", q, 8'h00);
      chk("irq off", {7'h00, irq}, 8'h00);
    end
    cal = 1'b1;
    hook = 1'b1;
    @(posedge clock);
    #1;
    u_host.rd(8'h14, q);
    chk("cal error", q, 8'h04);
    u_host.wr(8'h14, 8'h04);
    cal = 1'b0;
    hook = 1'b0;
    @(posedge clock);
    #1;
    u_host.rd(8'h14, q);
    chk("no cal error", q, 8'h00);
    conclude();
  end
endmodule
`default_nettype wire
